// >>> rtl/isrp_fifo.v
// synchronous fifo in flip-flops, valid/ready on both sides
`timescale 1ns/1ps
module isrp_fifo #(
	parameter W = 18,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire rst,
	input wire inValid,
	output wire inReady,
	input wire [W-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [W-1:0] outData
);
	reg [W-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0] wrPtr_ff;
	reg [AW-1:0] rdPtr_ff;
	reg [AW:0] count_ff;
	wire push;
	wire pop;
	localparam [AW:0] FULL_CNT = DEPTH;
	localparam [AW:0] ONE_CNT = 1;
	localparam [AW-1:0] ONE_PTR = 1;

	// honest flags from the occupancy count
	assign inReady = (count_ff != FULL_CNT);
	assign outValid = (count_ff != {(AW+1){1'b0}});
	assign push = inValid & inReady;
	assign pop = outValid & outReady;
	assign outData = mem_ff[rdPtr_ff];

	// storage is not reset, only pointers and count carry state
	always @(posedge clk) begin
		if (push) begin
			mem_ff[wrPtr_ff] <= inData;
		end
	end

	// pointers wrap naturally since depth is a power of two
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_ff <= {AW{1'b0}};
			rdPtr_ff <= {AW{1'b0}};
			count_ff <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wrPtr_ff <= wrPtr_ff + ONE_PTR;
			end
			if (pop) begin
				rdPtr_ff <= rdPtr_ff + ONE_PTR;
			end
			if (push & ~pop) begin
				count_ff <= count_ff + ONE_CNT;
			end else if (pop & ~push) begin
				count_ff <= count_ff - ONE_CNT;
			end
		end
	end
endmodule // isrp_fifo

// >>> rtl/isrp_regs.vh
// constants for the inertial sensor serial register port
`ifndef ISRP_REGS_VH
`define ISRP_REGS_VH
// ==========================================================
// frame and word layout
`define ISRP_WORD_W 16
`define ISRP_FRAME_LAST 5'h0f
`define ISRP_FRAME_BITS 5'h10
`define ISRP_CMD_WRITE_BIT 15
`define ISRP_ADDR_HI 13
`define ISRP_ADDR_LO 8
`define ISRP_ND_BIT 15
`define ISRP_EA_BIT 14
`define ISRP_MEAS_W 14
`define ISRP_SHORT_MASK 14'h0fff
// ==========================================================
// byte addresses of the output data registers (low byte)
`define ISRP_A_SUPPLY 6'h02
`define ISRP_A_RATE_X 6'h04
`define ISRP_A_RATE_Y 6'h06
`define ISRP_A_RATE_Z 6'h08
`define ISRP_A_ACCEL_X 6'h0a
`define ISRP_A_ACCEL_Y 6'h0c
`define ISRP_A_ACCEL_Z 6'h0e
`define ISRP_A_TEMP_X 6'h10
`define ISRP_A_TEMP_Y 6'h12
`define ISRP_A_TEMP_Z 6'h14
`define ISRP_A_AUX 6'h16
// ==========================================================
// word indices (byte address divided by two)
`define ISRP_W_FIRST 5'h01
`define ISRP_W_LAST 5'h0b
`define ISRP_W_TEMP_X 5'h08
`define ISRP_W_TEMP_Z 5'h0a
`define ISRP_W_AUX 5'h0b
`define ISRP_W_CFG_LO 5'h0d
`define ISRP_W_CFG_HI 5'h1d
`define ISRP_CFG_N 17
`define ISRP_CFG_LAST 5'h10
`define ISRP_W_STATUS 5'h1e
`define ISRP_W_COMMAND 5'h1f
`define ISRP_FLASH_BIT 3
// ==========================================================
// sample stream and buffer
`define ISRP_CHAN_W 4
`define ISRP_SMP_W 18
`define ISRP_FIFO_DEPTH 16
`define ISRP_FIFO_AW 4
`endif

// >>> rtl/isrp_spi_port.v
// serial register port of the six-axis inertial sensor
`timescale 1ns/1ps
`include "isrp_regs.vh"
module isrp_spi_port (
	input wire clk,
	input wire rst,
	input wire csN,
	input wire sclk,
	input wire mosi,
	output wire miso,
	output wire misoOeN,
	input wire smpValid,
	output wire smpReady,
	input wire [3:0] smpChan,
	input wire [13:0] smpData,
	input wire [15:0] statusCauses,
	output wire [4:0] nvAddr,
	input wire [15:0] nvRdData,
	output wire nvWrEn,
	output wire [15:0] nvWrData,
	output wire portReady,
	output wire [271:0] cfgWords
);
	// ==========================================================
	// sequencer states
	localparam [2:0] ST_LOAD = 3'h1;
	localparam [2:0] ST_RUN = 3'h2;
	localparam [2:0] ST_SAVE = 3'h4;
	localparam [4:0] ONE5 = 5'h01;

	// ==========================================================
	// decode helpers
	// output data words, supply through auxiliary
	function isSensor;
		input [4:0] idx;
		begin
			isSensor = (idx >= `ISRP_W_FIRST) && (idx <= `ISRP_W_LAST);
		end
	endfunction

	// working configuration words, all writable here
	function isCfg;
		input [4:0] idx;
		begin
			isCfg = (idx >= `ISRP_W_CFG_LO) && (idx <= `ISRP_W_CFG_HI);
		end
	endfunction

	// temperatures, supply and auxiliary carry 12-bit values
	function isShort;
		input [4:0] idx;
		begin
			isShort = ((idx >= `ISRP_W_TEMP_X) && (idx <= `ISRP_W_TEMP_Z)) ||
				(idx == `ISRP_W_AUX) || (idx == `ISRP_W_FIRST);
		end
	endfunction

	// ==========================================================
	// declarations
	reg csS1_ff, csS2_ff, csD_ff;
	reg sclkS1_ff, sclkS2_ff, sclkD_ff;
	reg mosiS1_ff, mosiS2_ff;
	reg [4:0] bitCnt_ff;
	reg [14:0] rxShift_ff;
	reg [15:0] txShift_ff;
	reg [15:0] respHold_ff;
	reg [2:0] state_ff;
	reg frameOk_ff;
	reg [4:0] seqIdx_ff;
	reg nvWrEn_ff;
	reg [15:0] nvWrData_ff;
	reg [15:0] cfgMem_ff [0:`ISRP_CFG_N-1];
	reg [13:0] meas_ff [`ISRP_W_FIRST:`ISRP_W_LAST];
	reg [`ISRP_W_LAST:`ISRP_W_FIRST] newFlag_ff;
	reg [15:0] nxt_resp;
	wire running;
	wire active;
	wire sclkRise;
	wire sclkFall;
	wire frameStart;
	wire frameDone;
	wire [15:0] rxWord;
	wire isWrite;
	wire [5:0] cmdAddr;
	wire [4:0] cmdWord;
	wire [4:0] cfgIdx;
	wire errFlag;
	wire flashReq;
	wire fifoValid;
	wire fifoReady;
	wire [17:0] fifoData;
	wire [4:0] drainIdx;
	wire drain;
	integer i;
	integer j;

	// ==========================================================
	// pin synchronisers, first stage feeds only the second
	// reset values match the idle pins, so no false edge follows reset
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			csS1_ff <= 1'b1;
			csS2_ff <= 1'b1;
			csD_ff <= 1'b1;
			sclkS1_ff <= 1'b1;
			sclkS2_ff <= 1'b1;
			sclkD_ff <= 1'b1;
			mosiS1_ff <= 1'b0;
			mosiS2_ff <= 1'b0;
		end else begin
			csS1_ff <= csN;
			csS2_ff <= csS1_ff;
			csD_ff <= csS2_ff;
			sclkS1_ff <= sclk;
			sclkS2_ff <= sclkS1_ff;
			sclkD_ff <= sclkS2_ff;
			mosiS1_ff <= mosi;
			mosiS2_ff <= mosiS1_ff;
		end
	end

	// edges are seen two to three clocks late; sclk must stay under clk/4
	assign running = (state_ff == ST_RUN);
	assign active = ~csS2_ff & running & frameOk_ff;
	assign sclkRise = sclkS2_ff & ~sclkD_ff;
	assign sclkFall = ~sclkS2_ff & sclkD_ff;
	assign frameStart = ~csS2_ff & csD_ff;
	assign frameDone = active & sclkRise & (bitCnt_ff == `ISRP_FRAME_LAST);
	assign rxWord = {rxShift_ff, mosiS2_ff};

	// a frame counts only if it opened while running; one that straddles
	// the end of restore or save is left alone until chip select rises
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			frameOk_ff <= 1'b0;
		end else if (csS2_ff) begin
			frameOk_ff <= 1'b0;
		end else if (frameStart) begin
			frameOk_ff <= running;
		end
	end

	// ==========================================================
	// receive side: bit count and shift register
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			bitCnt_ff <= 5'h00;
			rxShift_ff <= 15'h0000;
		end else if (~active) begin
			bitCnt_ff <= 5'h00;
		end else if (sclkRise && (bitCnt_ff < `ISRP_FRAME_BITS)) begin
			bitCnt_ff <= bitCnt_ff + ONE5; // extra clocks past 16 are ignored
			rxShift_ff <= rxWord[14:0];
		end
	end

	// ==========================================================
	// command decode of a finished frame
	// bit 14 of a command is not looked at; bit 15 alone marks a write
	assign isWrite = rxWord[`ISRP_CMD_WRITE_BIT];
	assign cmdAddr = rxWord[`ISRP_ADDR_HI:`ISRP_ADDR_LO];
	assign cmdWord = cmdAddr[5:1];
	assign cfgIdx = cmdWord - `ISRP_W_CFG_LO;
	assign flashReq = frameDone & isWrite & (cmdWord == `ISRP_W_COMMAND) &
		~cmdAddr[0] & rxWord[`ISRP_FLASH_BIT];
	assign errFlag = |statusCauses;

	// answer word for a read, whole register for either byte
	always @* begin
		nxt_resp = 16'h0000;
		if (isSensor(cmdWord)) begin
			nxt_resp = {newFlag_ff[cmdWord], errFlag, meas_ff[cmdWord]};
		end else if (isCfg(cmdWord)) begin
			nxt_resp = cfgMem_ff[cfgIdx];
		end else if (cmdWord == `ISRP_W_STATUS) begin
			nxt_resp = statusCauses;
		end
	end

	// ==========================================================
	// transmit side: answer of the previous frame goes out now
	// the first fall of a frame does not shift: its msb is already out
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			respHold_ff <= 16'h0000;
			txShift_ff <= 16'h0000;
		end else begin
			if (frameDone) begin
				respHold_ff <= isWrite ? 16'h0000 : nxt_resp;
			end
			if (frameStart) begin
				txShift_ff <= respHold_ff;
			end else if (active && sclkFall && (bitCnt_ff != 5'h00) &&
				(bitCnt_ff < `ISRP_FRAME_BITS)) begin
				txShift_ff <= {txShift_ff[14:0], 1'b0};
			end
		end
	end

	// output enable is active low: the synchronised select gated by running and frameOk_ff
	assign miso = txShift_ff[15];
	assign misoOeN = ~active;

	// ==========================================================
	// sample buffer between the measurement path and the registers
	// a full buffer refuses samples rather than overwrite the oldest
	isrp_fifo #(
		.W(`ISRP_SMP_W),
		.DEPTH(`ISRP_FIFO_DEPTH),
		.AW(`ISRP_FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.inValid(smpValid),
		.inReady(smpReady),
		.inData({smpChan, smpData}),
		.outValid(fifoValid),
		.outReady(fifoReady),
		.outData(fifoData)
	);

	// drain stalls during a frame so a word never changes mid-read
	assign fifoReady = running & csS2_ff;
	assign drain = fifoValid & fifoReady;
	assign drainIdx = {1'b0, fifoData[17:14]};

	// ==========================================================
	// measurement words and new-data flags
	// a read clear needs csN low and a drain csN high, so they never meet
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			newFlag_ff <= 11'h000;
			for (i = `ISRP_W_FIRST; i <= `ISRP_W_LAST; i = i + 1) begin
				meas_ff[i] <= 14'h0000;
			end
		end else begin
			// read clears first so that a same-cycle update wins
			if (frameDone && ~isWrite && isSensor(cmdWord)) begin
				newFlag_ff[cmdWord] <= 1'b0;
			end
			if (drain && isSensor(drainIdx)) begin
				newFlag_ff[drainIdx] <= 1'b1;
				if (isShort(drainIdx)) begin
					meas_ff[drainIdx] <= fifoData[13:0] & `ISRP_SHORT_MASK;
				end else begin
					meas_ff[drainIdx] <= fifoData[13:0];
				end
			end
		end
	end

	// ==========================================================
	// sequencer: restore, serve, persist; owns the working copy
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_LOAD;
			seqIdx_ff <= 5'h00;
			nvWrEn_ff <= 1'b0;
			nvWrData_ff <= 16'h0000;
			for (j = 0; j < `ISRP_CFG_N; j = j + 1) begin
				cfgMem_ff[j] <= 16'h0000;
			end
		end else begin
			nvWrEn_ff <= 1'b0;
			case (state_ff)
				ST_LOAD: begin
					// nvRdData must answer nvAddr within the same clock
					cfgMem_ff[seqIdx_ff] <= nvRdData;
					if (seqIdx_ff == `ISRP_CFG_LAST) begin
						seqIdx_ff <= 5'h00;
						state_ff <= ST_RUN;
					end else begin
						seqIdx_ff <= seqIdx_ff + ONE5;
					end
				end
				ST_RUN: begin
					// bytes land only from a complete frame
					if (frameDone && isWrite && isCfg(cmdWord)) begin
						if (cmdAddr[0]) begin
							cfgMem_ff[cfgIdx][15:8] <= rxWord[7:0];
						end else begin
							cfgMem_ff[cfgIdx][7:0] <= rxWord[7:0];
						end
					end
					if (flashReq) begin
						seqIdx_ff <= 5'h00;
						state_ff <= ST_SAVE;
					end
				end
				ST_SAVE: begin
					// one word per clock to the nonvolatile store
					nvWrEn_ff <= 1'b1;
					nvWrData_ff <= cfgMem_ff[seqIdx_ff];
					// step past the last word too, so nvAddr still leads by one
					seqIdx_ff <= seqIdx_ff + ONE5;
					if (seqIdx_ff == `ISRP_CFG_LAST) begin
						state_ff <= ST_RUN;
					end
				end
				default: begin
					// a stray state code restarts the restore
					state_ff <= ST_LOAD;
					seqIdx_ff <= 5'h00;
				end
			endcase
		end
	end

	// nvAddr leads nvWrData by one clock while saving
	// after a save nvAddr rests one past the last word
	assign nvAddr = seqIdx_ff;
	assign nvWrEn = nvWrEn_ff;
	assign nvWrData = nvWrData_ff;
	assign portReady = running;

	// working copy exposed to the rest of the sensor
	genvar g;
	generate
		for (g = 0; g < `ISRP_CFG_N; g = g + 1) begin : g_cfg
			assign cfgWords[g*16 +: 16] = cfgMem_ff[g];
		end
	endgenerate
endmodule // isrp_spi_port

// >>> tb/isrp_host_model.sv
// serial master model driving the register port link
`timescale 1ns/1ps
module isrp_host_model (
	output reg csN,
	output reg sclk,
	output reg mosi,
	input wire miso,
	input wire misoOeN
);
	// ====
	// idle: deselected, clock parked high
	initial begin
		csN = 1'b1;
		sclk = 1'b1;
		mosi = 1'b0;
	end
	// one frame, msb first; nb below 16 cuts the frame short
	task automatic xfer(input logic [15:0] tx, input int nb, output logic [15:0] rx);
		int i;
		rx = 16'h0000;
		csN = 1'b0;
		#200;
		for (i = 0; i < nb; i++) begin
			sclk = 1'b0;
			mosi = tx[15 - i];
			#200;
			sclk = 1'b1;
			rx = {rx[14:0], (misoOeN === 1'b0) ? miso : 1'bx};
			#200;
		end
		#200;
		csN = 1'b1;
		mosi = ~mosi; // released line must not show a stale bit
		#400;
	endtask
endmodule // isrp_host_model

// >>> tb/isrp_spi_port_assertions.sv
// port-level checker for the serial register port
`timescale 1ns/1ps
module isrp_spi_port_assertions (
	input wire clk,
	input wire rst,
	input wire csN,
	input wire misoOeN,
	input wire nvWrEn,
	input wire [4:0] nvAddr,
	input wire portReady,
	input wire [271:0] cfgWords
);
	reg [4:0] age_ff;
	reg [4:0] wrCnt_ff;
	// ====
	// cycles since reset, and words stored per save
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			age_ff <= 5'h00;
			wrCnt_ff <= 5'h00;
		end else begin
			age_ff <= (age_ff == 5'h1f) ? age_ff : age_ff + 5'h01;
			wrCnt_ff <= nvWrEn ? wrCnt_ff + 5'h01 : 5'h00;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_oe_deselect: assert property (csN [*5] |-> misoOeN)
		else $error("miso driven while deselected");
	a_oe_not_run: assert property (!portReady [*2] |-> misoOeN)
		else $error("miso driven outside run");
	a_oe_frame_start: assert property ($fell(csN) && portReady |-> ##[1:5] !misoOeN)
		else $error("miso not driven in frame");
	a_load_hold: assert property (age_ff <= 5'h10 |-> !portReady)
		else $error("ready before restore done");
	a_load_done: assert property (age_ff == 5'h11 |-> portReady)
		else $error("ready late after restore");
	a_save_first: assert property ($rose(nvWrEn) |-> nvAddr == 5'h01)
		else $error("save not starting at word 0");
	a_save_count: assert property ($fell(nvWrEn) |-> wrCnt_ff == 5'h11)
		else $error("save word count wrong");
	a_save_idle: assert property (nvWrEn |-> $past(!portReady))
		else $error("store pulse while running");
	a_cfg_in_frame: assert property ($changed(cfgWords) && $past(portReady, 2) |-> !csN)
		else $error("config changed outside frame");
	c_save: cover property ($rose(nvWrEn));
	c_write: cover property ($changed(cfgWords) && portReady);
	c_drive: cover property ($fell(misoOeN));
endmodule // isrp_spi_port_assertions
bind isrp_spi_port isrp_spi_port_assertions chk (.clk(clk), .rst(rst), .csN(csN),
	.misoOeN(misoOeN), .nvWrEn(nvWrEn), .nvAddr(nvAddr), .portReady(portReady),
	.cfgWords(cfgWords));

// >>> tb/isrp_spi_port_tb.sv
// self-checking bench for the serial register port
`timescale 1ns/1ps
module isrp_spi_port_tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg smpValid = 1'b0;
	reg [3:0] smpChan = 4'h0;
	reg [13:0] smpData = 14'h0000;
	reg [15:0] statusCauses = 16'h0000;
	wire csN, sclk, mosi, miso, misoOeN, smpReady, nvWrEn, portReady;
	wire [4:0] nvAddr;
	wire [15:0] nvRdData, nvWrData;
	wire [271:0] cfgWords;
	int failures = 0;
	int cmp_count = 0;
	int i, n;
	bit ok;
	logic [15:0] nvm [0:31];
	logic [15:0] nvx [0:16];
	logic [15:0] cfg [0:16];
	logic [13:0] val [1:11];
	logic nd [1:11];
	logic [15:0] pend, rx;
	// ====
	// clock, and a nonvolatile store that reads combinationally
	initial begin
		forever #25 clk = ~clk;
	end
	assign nvRdData = nvm[nvAddr];
	always @(posedge clk) if (nvWrEn === 1'b1) nvm[nvAddr - 5'h01] <= nvWrData;
	isrp_spi_port dut (.clk(clk), .rst(rst), .csN(csN), .sclk(sclk), .mosi(mosi),
		.miso(miso), .misoOeN(misoOeN), .smpValid(smpValid), .smpReady(smpReady),
		.smpChan(smpChan), .smpData(smpData), .statusCauses(statusCauses),
		.nvAddr(nvAddr), .nvRdData(nvRdData), .nvWrEn(nvWrEn), .nvWrData(nvWrData),
		.portReady(portReady), .cfgWords(cfgWords));
	isrp_host_model host (.csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso),
		.misoOeN(misoOeN));
	// ====
	// checking and model tasks
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	function automatic logic [15:0] expw(input logic [4:0] w);
		if (w >= 1 && w <= 11) return {nd[w], |statusCauses, val[w]};
		if (w >= 13 && w <= 29) return cfg[w - 13];
		if (w == 30) return statusCauses;
		return 16'h0000;
	endfunction
	// one frame; the answer is the word asked for by the frame before
	task automatic frame(input logic [15:0] cmd, input int nb);
		logic [4:0] w;
		w = cmd[13:9];
		@(negedge clk); // link edges stay clear of the sampling edge
		host.xfer(cmd, nb, rx);
		if (nb < 16) return;
		chk(rx, pend, "miso word");
		pend = cmd[15] ? 16'h0000 : expw(w);
		if (!cmd[15] && w >= 1 && w <= 11) nd[w] = 1'b0;
		if (cmd[15] && w >= 13 && w <= 29) begin
			if (cmd[8]) cfg[w - 13][15:8] = cmd[7:0];
			else cfg[w - 13][7:0] = cmd[7:0];
		end
	endtask
	task automatic push(input logic [3:0] ch, input logic [13:0] d);
		@(posedge clk);
		smpChan <= ch;
		smpData <= d;
		smpValid <= 1'b1;
		@(negedge clk);
		ok = smpReady;
		@(posedge clk);
		smpValid <= 1'b0;
		if (ok) val[ch] = (ch == 1 || ch >= 8) ? d & 14'h0fff : d;
		if (ok) nd[ch] = 1'b1;
	endtask
	task automatic cmp_cfg();
		for (i = 0; i < 17; i++) chk(cfgWords[i*16 +: 16], cfg[i], "config word");
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		cfg = nvx;
		pend = 16'h0000;
		foreach (val[k]) begin
			val[k] = 14'h0000;
			nd[k] = 1'b0;
		end
		for (n = 0; n < 200 && portReady !== 1'b1; n++) @(negedge clk);
		if (portReady !== 1'b1) begin
			failures++;
			$display("[ERR] %0t port never ready", $time);
			end_of_test();
		end
		chk({15'h0000, misoOeN}, 16'h0001, "miso float");
		cmp_cfg();
		$display("reset test done");
	endtask
	task automatic rd_all();
		for (i = 0; i < 32; i++) frame({2'h0, 5'(i), i[0], 8'($urandom)}, 16);
		$display("read pass done");
	endtask
	task automatic wr_some();
		for (i = 0; i < 6; i++) frame({2'h2, 6'h1a + 6'($urandom_range(33)), 8'($urandom)}, 16);
		frame({2'h2, 6'h05, 8'hff}, 16);
		frame({2'h2, 6'h1b, 8'h77}, 12);
		cmp_cfg();
	endtask
	// ====
	// main sequence
	initial begin
		n = $urandom(23);
		foreach (nvm[k]) nvm[k] = {3'h5, 5'(k), 8'h3c};
		for (i = 0; i < 17; i++) nvx[i] = nvm[i];
		do_reset();
		statusCauses <= 16'(1 << $urandom_range(15));
		for (i = 1; i < 12; i++) push(4'(i), 14'($urandom));
		repeat (8) @(posedge clk);
		rd_all();
		statusCauses <= 16'h0000;
		rd_all();
		n = 0;
		fork
			frame({2'h0, 6'h3c, 8'h00}, 16);
			begin
				repeat (20) @(posedge clk);
				for (i = 0; i < 20; i++) begin
					push(4'h2, 14'(i));
					n += ok;
				end
			end
		join
		chk(16'(n), 16'h0010, "taken while held");
		$display("buffer test done");
		rd_all();
		wr_some();
		rd_all();
		do_reset();
		wr_some();
		frame({2'h2, 6'h3e, 8'h08}, 16);
		for (n = 0; n < 100 && portReady !== 1'b1; n++) @(negedge clk);
		chk({15'h0000, portReady}, 16'h0001, "save finished");
		nvx = cfg;
		do_reset();
		end_of_test();
	end
endmodule // isrp_spi_port_tb
